// file: verilog/mpo_cfg.svh
`ifndef MPO_CFG_SVH
`define MPO_CFG_SVH
`define MPO_ADDR_W 5
`define MPO_OFS_CTRL 5'h00
`define MPO_OFS_CONFIG 5'h04
`define MPO_OFS_OVR 5'h08
`define MPO_OFS_GAP 5'h0C
`define MPO_OFS_MAP 5'h10
`define MPO_OFS_STAT 5'h14
`define MPO_CTRL_EN 0
`define MPO_CTRL_OVR 1
`define MPO_CTRL_SOFT_DISABLE_BANK_X 2
`define MPO_CTRL_SOFT_DISABLE_BANK_Y 3
`define MPO_CTRL_FMODE1 4
`define MPO_CTRL_FMODE4 5
`define MPO_CTRL_FINT1 6
`define MPO_CTRL_FINT4 7
`define MPO_CFG_INDEPENDENT_CHANNEL_OPTION 0
`define MPO_CFG_TOPINV 1
`define MPO_CFG_BOTINV 2
`define MPO_STAT_FLAG1 0
`define MPO_STAT_FLAG4 1
`define MPO_STAT_PIN1 2
`define MPO_STAT_PIN4 3
`define MPO_STAT_OUT 4
`define MPO_CTRL_RST 8'h00
`define MPO_CONFIG_RST 3'h0
`define MPO_OVR_RST 6'h00
`define MPO_GAP_RST 8'hFF
`define MPO_MAP_RST 8'hFF
`define MPO_RESP_OK 2'h0
`define MPO_RESP_ERR 2'h2
`endif

// file: verilog/mpo_pkg.sv
package mpo_pkg;
  typedef enum logic [2:0] {
    MPO_DT_GAP = 3'h1,
    MPO_DT_TOP = 3'h2,
    MPO_DT_BOT = 3'h4
  } mpo_dt_state_t;
endpackage

// file: verilog/mpo_output_stage.sv
// What this block does
// R01 - Option picks six independent channels or three pairs sharing one duty source.
// R02 - Independent mode drives each output from its own duty channel.
// R03 - Dead-time is an 8-bit write-once count of clock cycles.
// R04 - Dead-time does not depend on the period prescaler.
// R05 - Dead-time input is generator top channel, or odd override bit under override.
// R06 - Each dead-time input change holds both outputs inactive for dead-time.
// R07 - Complementary bottom output comes from top signal and dead-time.
// R08 - One polarity option for outputs 1,3,5; another for 2,4,6.
// R09 - Positive polarity drives active high; negative drives active low.
// R10 - Polarity options sit in a write-once register until reset.
// R11 - Override drives pins from six bits; independent: one active, zero inactive.
// R12 - Complementary override: odd bit sets top; even bit allows complement bottom.
// R13 - Override keeps polarity; complementary override never both active, never violates dead-time.
// R14 - Odd override toggles insert dead-time; even bit changes never overlap.
// R15 - Override leaves generator running and works with modulator disabled.
// R16 - Leaving override returns generator to pins at next cycle start.
// R17 - Software clears override bits before entering and leaving override.
// R18 - Fault high or disable bit forces mapped outputs inactive.
// R19 - Fault 1 with disable X is bank X; fault 4 with Y bank Y.
// R20 - All-ones mapping makes any bank disable force all outputs.
// R21 - Each fault input raises its own interrupt request.
// R22 - Manual mode: fault 4 clears only if input low; fault 1 always.
// R23 - Automatic mode re-enables after filtered input low and new cycle.
// R24 - Per-fault mode bit: set automatic, clear manual.
// R25 - Forced-inactive outputs drive the polarity's inactive level.
`timescale 1ns/100ps
`default_nettype none
`include "mpo_cfg.svh"
module mpo_output_stage
  import mpo_pkg::*;
#(
  parameter int N_PAIR = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`MPO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`MPO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2*N_PAIR-1:0] gen_out,
  input wire logic cycle_start,
  input wire logic fault1_pin,
  input wire logic fault4_pin,
  output logic [2*N_PAIR-1:0] pwm_pin,
  output logic pwm_oe,
  output logic irq_fault1,
  output logic irq_fault4
);
  localparam int NCH = 2 * N_PAIR;

  // Register bus slave.
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [2:0] config_ff, nxt_config;
  logic config_lock_ff, nxt_config_lock;
  logic [NCH-1:0] ovr_ff, nxt_ovr;
  logic [7:0] gap_ff, nxt_gap;
  logic gap_lock_ff, nxt_gap_lock;
  logic [7:0] map_ff, nxt_map;
  logic map_lock_ff, nxt_map_lock;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] ack_w;
  logic wr_go, rd_go;
  logic [1:0] flag_ff, pin_filt_ff;
  logic [NCH-1:0] pin_ff;

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign rd_go = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_config = config_ff;
    nxt_config_lock = config_lock_ff;
    nxt_ovr = ovr_ff;
    nxt_gap = gap_ff;
    nxt_gap_lock = gap_lock_ff;
    nxt_map = map_ff;
    nxt_map_lock = map_lock_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    ack_w = 2'h0;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = `MPO_RESP_OK;
      case (s_axi_awaddr)
        `MPO_OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            nxt_ctrl = s_axi_wdata[7:0];
          end
        end
        `MPO_OFS_CONFIG: begin
          // Polarity is locked after the first write so a stray store cannot flip a gate drive.
          if (s_axi_wstrb[0] && !config_lock_ff) begin // R10
            nxt_config = s_axi_wdata[2:0];
            nxt_config_lock = 1'b1;
          end
        end
        `MPO_OFS_OVR: begin
          if (s_axi_wstrb[0]) begin
            nxt_ovr = s_axi_wdata[NCH-1:0];
          end
        end
        `MPO_OFS_GAP: begin
          if (s_axi_wstrb[0] && !gap_lock_ff) begin // R03
            nxt_gap = s_axi_wdata[7:0];
            nxt_gap_lock = 1'b1;
          end
        end
        `MPO_OFS_MAP: begin
          if (s_axi_wstrb[0] && !map_lock_ff) begin
            nxt_map = s_axi_wdata[7:0];
            nxt_map_lock = 1'b1;
          end
        end
        `MPO_OFS_STAT: begin
          if (s_axi_wstrb[0]) begin
            ack_w = s_axi_wdata[1:0];
          end
        end
        default: begin
          nxt_bresp = `MPO_RESP_ERR;
        end
      endcase
    end
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `MPO_RESP_OK;
      nxt_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `MPO_OFS_CTRL: nxt_rdata[7:0] = ctrl_ff;
        `MPO_OFS_CONFIG: nxt_rdata[2:0] = config_ff;
        `MPO_OFS_OVR: nxt_rdata[NCH-1:0] = ovr_ff;
        `MPO_OFS_GAP: nxt_rdata[7:0] = gap_ff;
        `MPO_OFS_MAP: nxt_rdata[7:0] = map_ff;
        `MPO_OFS_STAT: begin
          nxt_rdata[`MPO_STAT_FLAG4:`MPO_STAT_FLAG1] = flag_ff;
          nxt_rdata[`MPO_STAT_PIN4:`MPO_STAT_PIN1] = pin_filt_ff;
          nxt_rdata[`MPO_STAT_OUT+NCH-1:`MPO_STAT_OUT] = pin_ff;
        end
        default: nxt_rresp = `MPO_RESP_ERR;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `MPO_CTRL_RST;
      config_ff <= `MPO_CONFIG_RST;
      config_lock_ff <= 1'b0;
      ovr_ff <= `MPO_OVR_RST;
      gap_ff <= `MPO_GAP_RST;
      gap_lock_ff <= 1'b0;
      map_ff <= `MPO_MAP_RST;
      map_lock_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      config_ff <= nxt_config;
      config_lock_ff <= nxt_config_lock;
      ovr_ff <= nxt_ovr;
      gap_ff <= nxt_gap;
      gap_lock_ff <= nxt_gap_lock;
      map_ff <= nxt_map;
      map_lock_ff <= nxt_map_lock;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Fault inputs: two-stage synchroniser, then a two-sample rising filter.
  logic [1:0] meta_ff, sync_ff, smp_ff;
  logic [1:0] nxt_smp, nxt_pin_filt, nxt_flag, rise;
  logic [1:0] fault_act_ff, nxt_fault_act;
  logic [1:0] sdis_act_ff, nxt_sdis_act;
  logic sel_ovr_ff, nxt_sel_ovr;
  logic [1:0] fault_reenable_select, sdis;
  logic boundary;

  assign fault_reenable_select = {ctrl_ff[`MPO_CTRL_FMODE4], ctrl_ff[`MPO_CTRL_FMODE1]};
  assign sdis = {ctrl_ff[`MPO_CTRL_SOFT_DISABLE_BANK_Y], ctrl_ff[`MPO_CTRL_SOFT_DISABLE_BANK_X]};
  // Without periodic cycles under override, every clock counts as a cycle start.
  assign boundary = cycle_start | ctrl_ff[`MPO_CTRL_OVR];

  always_comb begin
    nxt_smp = sync_ff;
    nxt_pin_filt = pin_filt_ff;
    rise = 2'h0;
    for (int b = 0; b < 2; b++) begin
      if (sync_ff[b] && smp_ff[b] && !pin_filt_ff[b]) begin
        nxt_pin_filt[b] = 1'b1;
        rise[b] = 1'b1;
      end else if (!sync_ff[b]) begin
        nxt_pin_filt[b] = 1'b0;
      end
    end
    // A fresh rise wins over an acknowledge in the same cycle.
    nxt_flag = (flag_ff & ~ack_w) | rise;
    nxt_fault_act = fault_act_ff;
    for (int b = 0; b < 2; b++) begin
      if (rise[b]) begin
        nxt_fault_act[b] = 1'b1; // R18
      end else if (boundary) begin
        if (fault_reenable_select[b]) begin
          if (!nxt_pin_filt[b]) begin
            nxt_fault_act[b] = 1'b0; // R23 R24
          end
        end else if (!flag_ff[b] && (b == 0 || !nxt_pin_filt[b])) begin
          // Manual fault 1 re-arms on acknowledge even while its input is still high.
          nxt_fault_act[b] = 1'b0; // R22
        end
      end
    end
    nxt_sdis_act = sdis_act_ff;
    for (int b = 0; b < 2; b++) begin
      if (sdis[b]) begin
        nxt_sdis_act[b] = 1'b1; // R18
      end else if (boundary) begin
        nxt_sdis_act[b] = 1'b0;
      end
    end
    nxt_sel_ovr = sel_ovr_ff;
    if (ctrl_ff[`MPO_CTRL_OVR]) begin
      nxt_sel_ovr = 1'b1;
    end else if (cycle_start) begin
      nxt_sel_ovr = 1'b0; // R16
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= 2'h0;
      sync_ff <= 2'h0;
      smp_ff <= 2'h0;
      pin_filt_ff <= 2'h0;
      flag_ff <= 2'h0;
      fault_act_ff <= 2'h0;
      sdis_act_ff <= 2'h0;
      sel_ovr_ff <= 1'b0;
    end else begin
      meta_ff <= {fault4_pin, fault1_pin};
      sync_ff <= meta_ff;
      smp_ff <= nxt_smp;
      pin_filt_ff <= nxt_pin_filt;
      flag_ff <= nxt_flag;
      fault_act_ff <= nxt_fault_act;
      sdis_act_ff <= nxt_sdis_act;
      sel_ovr_ff <= nxt_sel_ovr;
    end
  end

  assign irq_fault1 = flag_ff[0] & ctrl_ff[`MPO_CTRL_FINT1]; // R21
  assign irq_fault4 = flag_ff[1] & ctrl_ff[`MPO_CTRL_FINT4]; // R21

  // Source selection and disable decode.
  logic [NCH-1:0] src, act, kill, mask_x, mask_y;
  logic independent_channel_option;
  logic [1:0] bank_off;

  assign independent_channel_option = config_ff[`MPO_CFG_INDEPENDENT_CHANNEL_OPTION];
  // The generator keeps running under override; its outputs are simply not selected.
  assign src = sel_ovr_ff ? ovr_ff : (ctrl_ff[`MPO_CTRL_EN] ? gen_out : '0); // R05 R15 R11
  assign bank_off = fault_act_ff | sdis_act_ff; // R19
  assign mask_x = map_ff[NCH-1:0];
  assign mask_y = {map_ff[7:6], map_ff[3:0]};
  assign kill = ({NCH{bank_off[0]}} & mask_x) | ({NCH{bank_off[1]}} & mask_y); // R19 R20

  genvar p;
  generate
    for (p = 0; p < N_PAIR; p++) begin : g_pair
      mpo_dt_state_t st_ff, nxt_st;
      logic [7:0] cnt_ff, nxt_cnt;
      logic prev_ff, nxt_prev;
      logic din;

      assign din = src[2*p]; // R05

      always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_prev = din;
        // The gap counts raw clocks, so the prescaler never stretches it.
        if (din != prev_ff) begin
          nxt_st = MPO_DT_GAP; // R06 R14
          nxt_cnt = gap_ff; // R04
        end else begin
          case (st_ff)
            MPO_DT_GAP: begin
              if (cnt_ff == 8'h00) begin
                nxt_st = din ? MPO_DT_TOP : MPO_DT_BOT;
              end else begin
                nxt_cnt = cnt_ff - 8'h01;
              end
            end
            MPO_DT_TOP: nxt_st = MPO_DT_TOP;
            MPO_DT_BOT: nxt_st = MPO_DT_BOT;
            default: nxt_st = MPO_DT_GAP;
          endcase
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_ff <= MPO_DT_BOT;
          cnt_ff <= 8'h00;
          prev_ff <= 1'b0;
        end else begin
          st_ff <= nxt_st;
          cnt_ff <= nxt_cnt;
          prev_ff <= nxt_prev;
        end
      end

      always_comb begin
        if (independent_channel_option) begin
          act[2*p] = src[2*p]; // R02
          act[2*p+1] = src[2*p+1]; // R02 R11
        end else begin
          act[2*p] = (st_ff == MPO_DT_TOP); // R01 R13
          // Even override bit only gates the bottom, which is already dead-timed against the top.
          act[2*p+1] = (st_ff == MPO_DT_BOT) & (~sel_ovr_ff | ovr_ff[2*p+1]); // R07 R12 R14
        end
      end
    end
  endgenerate

  // Pin stage: mask, then polarity, registered so pins never glitch.
  logic [NCH-1:0] nxt_pin, inv;
  logic oe_ff, nxt_oe;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      inv[i] = (i % 2 == 0) ? config_ff[`MPO_CFG_TOPINV] : config_ff[`MPO_CFG_BOTINV]; // R08
    end
    nxt_pin = (act & ~kill) ^ inv; // R09 R13 R18 R25
    nxt_oe = ctrl_ff[`MPO_CTRL_EN] | ctrl_ff[`MPO_CTRL_OVR]; // R15
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_ff <= '0;
      oe_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
      oe_ff <= nxt_oe;
    end
  end

  assign pwm_pin = pin_ff;
  assign pwm_oe = oe_ff;
endmodule
`default_nettype wire

// file: dv/mpo_output_stage_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "mpo_cfg.svh"
module mpo_output_stage_properties #(
  parameter int N_PAIR = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`MPO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic [`MPO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [2*N_PAIR-1:0] gen_out,
  input wire logic fault1_pin,
  input wire logic fault4_pin,
  input wire logic [2*N_PAIR-1:0] pwm_pin
);
  logic [2:0] cfg_ff, st_ff;
  logic [7:0] ctrl_ff, gap_ff;
  logic [5:0] ovr_ff;
  logic cfg_lk_ff, gap_lk_ff, map_lk_ff, calm_ff, pure_ff, tk;
  logic [2*N_PAIR-1:0] act;
  assign tk = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & s_axi_wstrb[0];
  assign act = pwm_pin ^ {N_PAIR{cfg_ff[2], cfg_ff[1]}};
  // Pins lag the registers, so pin checks wait until writes have settled.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {cfg_ff, ctrl_ff, gap_ff, ovr_ff, st_ff} <= {3'h0, 8'h00, 8'hFF, 6'h00, 3'h0};
      {cfg_lk_ff, gap_lk_ff, map_lk_ff, calm_ff, pure_ff} <= 5'h03;
    end else begin
      st_ff <= tk ? 3'h0 : st_ff + {2'h0, st_ff != 3'h7};
      calm_ff <= calm_ff & ~fault1_pin & ~fault4_pin & ~ctrl_ff[2] & ~ctrl_ff[3];
      pure_ff <= pure_ff & ~ctrl_ff[1];
      if (tk && s_axi_awaddr == `MPO_OFS_CTRL) begin
        ctrl_ff <= s_axi_wdata[7:0];
      end
      if (tk && s_axi_awaddr == `MPO_OFS_OVR) begin
        ovr_ff <= s_axi_wdata[5:0];
      end
      if (tk && s_axi_awaddr == `MPO_OFS_CONFIG && !cfg_lk_ff) begin
        {cfg_ff, cfg_lk_ff} <= {s_axi_wdata[2:0], 1'b1};
      end
      if (tk && s_axi_awaddr == `MPO_OFS_GAP && !gap_lk_ff) begin
        {gap_ff, gap_lk_ff} <= {s_axi_wdata[7:0], 1'b1};
      end
      if (tk && s_axi_awaddr == `MPO_OFS_MAP) begin
        map_lk_ff <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bus_wr;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid;
  endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("Write answer late.");
  property p_rd_err;
    s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 5'h14 |=> s_axi_rvalid && s_axi_rresp == `MPO_RESP_ERR;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("Unmapped read not refused.");
  property p_overlap;
    !cfg_ff[0] && st_ff > 3'h2 |-> (act & (act >> 1) & {N_PAIR{2'b01}}) == '0;
  endproperty
  a_overlap: assert property (p_overlap) else $error("Pair active together.");
  property p_soft_dis;
    (ctrl_ff[2] || ctrl_ff[3]) && !map_lk_ff && st_ff > 3'h2 |-> act == '0;
  endproperty
  a_soft_dis: assert property (p_soft_dis) else $error("Disabled pin active.");
  property p_fault;
    $rose(fault1_pin) ##0 fault1_pin [*8] |=> act[3:0] == 4'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault did not mask.");
  property p_independent_channel_option;
    cfg_ff[0] && ctrl_ff[0] && pure_ff && calm_ff && st_ff > 3'h2 |-> act == $past(gen_out);
  endproperty
  a_independent_channel_option: assert property (p_independent_channel_option) else $error("Pin not following its channel.");
  property p_ovr;
    cfg_ff[0] && ctrl_ff[1] && calm_ff && st_ff > 3'h2 |-> act == ovr_ff;
  endproperty
  a_ovr: assert property (p_ovr) else $error("Pin not following override.");
  property p_gap;
    !cfg_ff[0] && ctrl_ff[0] && pure_ff && calm_ff && gap_ff == 8'h03 && st_ff > 3'h2 && $rose(gen_out[0])
      |-> ##2 (act[1:0] == 2'b00) [*4] ##1 act[1:0] == 2'b01;
  endproperty
  a_gap: assert property (p_gap) else $error("Dead-time length wrong.");
endmodule
bind mpo_output_stage mpo_output_stage_properties #(.N_PAIR(N_PAIR)) u_props (.clk, .rst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_rvalid, .s_axi_rresp, .gen_out, .fault1_pin, .fault4_pin, .pwm_pin);
`default_nettype wire

// file: dv/mpo_gate_drv_model.sv
`timescale 1ns/100ps
`default_nettype none
module mpo_gate_drv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] pin,
  input wire logic oe,
  input wire logic top_inv,
  input wire logic bot_inv,
  output logic [5:0] gate_on,
  output logic shoot
);
  // A floating pin leaves the driver off, as its input pull keeps the gate low.
  assign gate_on = oe ? pin ^ {3{bot_inv, top_inv}} : 6'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shoot <= 1'b0;
    end else begin
      shoot <= shoot | (|(gate_on & (gate_on >> 1) & 6'h15));
    end
  end
endmodule
`default_nettype wire

// file: dv/mpo_output_stage_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mpo_cfg.svh"
module mpo_output_stage_bench;
  logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, cyc = 1'b0, f1 = 1'b0, f4 = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oe, irq1, irq4, shoot;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [5:0] gen = 6'h00, pin, gate;
  int mismatches = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  mpo_output_stage dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .gen_out(gen), .cycle_start(cyc),
    .fault1_pin(f1), .fault4_pin(f4), .pwm_pin(pin), .pwm_oe(oe), .irq_fault1(irq1), .irq_fault4(irq4));
  mpo_gate_drv_model drv (.clk(clk), .rst(rst), .pin(pin), .oe(oe), .top_inv(1'b1), .bot_inv(1'b0),
    .gate_on(gate), .shoot(shoot));
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
    do @(negedge clk); while (!(awready && wready));
    @(posedge clk);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge clk); while (!bvalid);
    check({30'h0, bresp}, 32'h0);
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    {araddr, arvalid} <= {a, 1'b1};
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    {d, r} = {rdata, rresp};
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check({d[31:8], d[7:0]}, e);
  endtask
  task automatic pc(input int n, input logic [5:0] e);
    repeat (n) @(posedge clk);
    @(negedge clk);
    check({26'h0, pin}, {26'h0, e});
    @(posedge clk);
  endtask
  task automatic cs();
    cyc <= 1'b1;
    @(posedge clk);
    cyc <= 1'b0;
  endtask
  task automatic gap(input logic [5:0] g, input logic [1:0] fin);
    int n;
    n = 0;
    gen <= g;
    repeat (16) begin
      @(negedge clk);
      n += int'(pin[1:0] == 2'b01);
    end
    check(n, 4);
    check({30'h0, pin[1:0]}, {30'h0, fin});
    @(posedge clk);
  endtask
  task automatic s_regs();
    logic [31:0] d;
    logic [1:0] r;
    rdchk(`MPO_OFS_GAP, 32'hFF);
    rdchk(`MPO_OFS_MAP, 32'hFF);
    rd(5'h18, d, r);
    check({30'h0, r}, 32'h2);
    pc(0, 6'h2A);
    wr(`MPO_OFS_CONFIG, 32'h2);
    wr(`MPO_OFS_CONFIG, 32'h7);
    rdchk(`MPO_OFS_CONFIG, 32'h2);
    wr(`MPO_OFS_GAP, 32'h3);
    wr(`MPO_OFS_GAP, 32'h9);
    rdchk(`MPO_OFS_GAP, 32'h3);
    pc(3, 6'h3F);
  endtask
  task automatic s_gap();
    wr(`MPO_OFS_CTRL, 32'h1);
    gen <= 6'h02;
    repeat (5) @(posedge clk);
    gap(6'h03, 2'b00);
    gap(6'h02, 2'b11);
  endtask
  task automatic s_ovr();
    wr(`MPO_OFS_CTRL, 32'h2);
    pc(4, 6'h15);
    gen <= 6'h00;
    wr(`MPO_OFS_OVR, 32'h01);
    pc(12, 6'h14);
    wr(`MPO_OFS_OVR, 32'h02);
    pc(12, 6'h17);
    wr(`MPO_OFS_OVR, 32'h00);
    gen <= 6'h01;
    wr(`MPO_OFS_CTRL, 32'h1);
    pc(8, 6'h15);
    cs();
    pc(12, 6'h3C);
  endtask
  task automatic s_dis();
    wr(`MPO_OFS_CTRL, 32'h5);
    pc(4, 6'h15);
    wr(`MPO_OFS_CTRL, 32'h9);
    pc(4, 6'h15);
    wr(`MPO_OFS_CTRL, 32'h1);
    cs();
    pc(12, 6'h3C);
    check({31'h0, shoot}, 32'h0);
  endtask
  task automatic s_independent_channel_option();
    wr(`MPO_OFS_CONFIG, 32'h1);
    wr(`MPO_OFS_CTRL, 32'h1);
    gen <= 6'h2D;
    pc(4, 6'h2D);
    gen <= 6'h12;
    pc(3, 6'h12);
    wr(`MPO_OFS_CTRL, 32'h2);
    wr(`MPO_OFS_OVR, 32'h35);
    pc(3, 6'h35);
    check({31'h0, oe}, 32'h1);
    wr(`MPO_OFS_OVR, 32'h00);
    wr(`MPO_OFS_CTRL, 32'h1);
    cs();
    pc(3, 6'h12);
  endtask
  task automatic s_fault();
    wr(`MPO_OFS_MAP, 32'h0F);
    wr(`MPO_OFS_CTRL, 32'hC1);
    {gen, f1} <= {6'h3F, 1'b1};
    pc(8, 6'h30);
    check({30'h0, irq4, irq1}, 32'h1);
    wr(`MPO_OFS_STAT, 32'h1);
    cs();
    pc(3, 6'h3F);
    {f1, f4} <= 2'b01;
    pc(8, 6'h30);
    check({30'h0, irq4, irq1}, 32'h2);
    wr(`MPO_OFS_STAT, 32'h2);
    cs();
    pc(3, 6'h30);
    wr(`MPO_OFS_CTRL, 32'h61);
    f4 <= 1'b0;
    repeat (6) @(posedge clk);
    cs();
    pc(3, 6'h3F);
  endtask
  initial begin
    #100us;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_gap();
    s_ovr();
    s_dis();
    {rst, gen} <= {1'b1, 6'h00};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    s_independent_channel_option();
    s_fault();
    print_verdict();
  end
endmodule
`default_nettype wire
